//--- rtl/dlm_regs.sv
// dlm_regs: latch-load strobes, channel mode and power registers
// Notes on behaviour
// - strobe write 1 loads data when latched
// - strobe bits self-clear at transaction end
// - bit 15..12 map channel 3..0 strobes
// - mode bits 15:12, 1 means current output
// - reserved bits read zero, reset zero
// - transparent channel passes data straight through
// - power bits 11:8, 1 means powered on
// - host overcurrent mode clears power bit
`timescale 1ns/10ps
`default_nettype none
module dlm_regs
    import dlm_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    // register port from the spi frame decoder
    input  wire logic         reg_wr,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [15:0]  reg_wdata,
    input  wire logic         frame_done,
    output logic      [15:0]  reg_rdata,
    // neighbouring configuration and data
    input  wire logic [3:0]   latch_transparent_cfg,
    input  wire logic         overcurrent_response_cfg,
    input  wire logic [47:0]  ch_data,
    input  wire logic [3:0]   ch_data_wr,
    input  wire logic [3:0]   overcurrent_det,
    input  wire logic         external_latch_pin,
    // converter side
    output logic      [47:0]  dac_code,
    output logic      [3:0]   output_kind_select,
    output logic      [3:0]   channel_power_on,
    output logic      [3:0]   load_strobe
);
    // elaboration check: port widths are fixed at four channels
    if (CH != NUM_CH) begin : g_bad_ch
        $error("only four channels supported");
    end

    // ==================================================
    // reset release and pin synchronisers
    logic       rst_s1_q, rst_n_q;
    logic [1:0] pin_sync_q;
    logic [3:0] ovc_s1_q, ovc_s2_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // async pins pass two flops before use
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_sync_q <= 2'b00;
            ovc_s1_q   <= 4'h0;
            ovc_s2_q   <= 4'h0;
        end else if (clk_en) begin
            pin_sync_q <= {pin_sync_q[0], external_latch_pin};
            ovc_s1_q   <= overcurrent_det;
            ovc_s2_q   <= ovc_s1_q;
        end
    end

    // ==================================================
    // register state
    logic [3:0]  strobe_q, strobe_d;
    logic [3:0]  kind_q, kind_d;
    logic [3:0]  pwr_q, pwr_d;
    logic [47:0] code_q, code_d;
    logic        pin_q, pin_d;
    logic        wr_ctl, wr_mode, pin_rise;

    // address decode shared by write enables and the read mux
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] r);
        return a == r;
    endfunction

    assign wr_ctl   = reg_wr && addr_hit(reg_addr, ADDR_LATCH_LOAD);
    assign wr_mode  = reg_wr && addr_hit(reg_addr, ADDR_MODE_PWR);
    assign pin_rise = pin_sync_q[1] && !pin_q;

    // next-state: strobes, mode, power, converter codes
    always_comb begin
        strobe_d = strobe_q;
        kind_d   = kind_q;
        pwr_d    = pwr_q;
        code_d   = code_q;
        pin_d    = pin_sync_q[1];
        if (frame_done) strobe_d = 4'h0;
        if (wr_ctl) strobe_d = reg_wdata[STROBE_LSB +: 4];
        if (wr_mode) begin
            kind_d = reg_wdata[KIND_LSB +: 4];
            pwr_d  = reg_wdata[PWR_LSB +: 4];
        end
        for (int i = 0; i < 4; i++) begin
            // overcurrent clear wins: the channel is already down
            if (overcurrent_response_cfg && ovc_s2_q[i])
                pwr_d[i] = 1'b0;
            if (latch_transparent_cfg[i]) begin
                if (ch_data_wr[i])
                    code_d[i*12 +: 12] = ch_data[i*12 +: 12];
            end else if ((wr_ctl && reg_wdata[STROBE_LSB + i]) || pin_rise)
                code_d[i*12 +: 12] = ch_data[i*12 +: 12];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strobe_q <= 4'h0;
            kind_q   <= KIND_RST;
            pwr_q    <= PWR_RST;
            code_q   <= {4{DATA_RST}};
            pin_q    <= 1'b0;
        end else if (clk_en) begin
            strobe_q <= strobe_d;
            kind_q   <= kind_d;
            pwr_q    <= pwr_d;
            code_q   <= code_d;
            pin_q    <= pin_d;
        end
    end

    // ==================================================
    // read mux: strobes and reserved read as zero
    always_comb begin
        reg_rdata = 16'h0000;
        if (addr_hit(reg_addr, ADDR_MODE_PWR))
            reg_rdata = {kind_q, pwr_q, 8'h00};
    end

    assign dac_code           = code_q;
    assign output_kind_select = kind_q;
    assign channel_power_on   = pwr_q;
    assign load_strobe        = strobe_q;

    // ==================================================
    // checks
    // per-channel load behaviour, one copy for each converter
    for (genvar g = 0; g < 4; g++) begin : g_ch_chk
        // strobe with a 1 on a latched channel
        sequence s_strobe_one;
            clk_en && wr_ctl && reg_wdata[STROBE_LSB + g]
            && !latch_transparent_cfg[g];
        endsequence
        // synchronised pin edge on a latched channel
        sequence s_pin_edge;
            clk_en && pin_rise && !latch_transparent_cfg[g];
        endsequence
        // data register write on a transparent channel
        sequence s_data_pass;
            clk_en && latch_transparent_cfg[g] && ch_data_wr[g];
        endsequence
        // latched channel with neither strobe nor pin edge
        sequence s_latch_idle;
            clk_en && !latch_transparent_cfg[g] && !pin_rise
            && !(wr_ctl && reg_wdata[STROBE_LSB + g]);
        endsequence
        property p_load;
            @(posedge ref_clk) disable iff (!rst_n_q)
            s_strobe_one
            |=> dac_code[g*12 +: 12] == $past(ch_data[g*12 +: 12]);
        endproperty
        a_load: assert property (p_load) else $error("load missed");
        property p_pin;
            @(posedge ref_clk) disable iff (!rst_n_q)
            s_pin_edge
            |=> dac_code[g*12 +: 12] == $past(ch_data[g*12 +: 12]);
        endproperty
        a_pin: assert property (p_pin) else $error("pin load missed");
        property p_transp;
            @(posedge ref_clk) disable iff (!rst_n_q)
            s_data_pass
            |=> dac_code[g*12 +: 12] == $past(ch_data[g*12 +: 12]);
        endproperty
        a_transp: assert property (p_transp) else $error("no bypass");
        // a zero strobe must leave a latched code alone
        property p_keep;
            @(posedge ref_clk) disable iff (!rst_n_q)
            s_latch_idle |=> $stable(dac_code[g*12 +: 12]);
        endproperty
        a_keep: assert property (p_keep) else $error("code moved");
    end
    property p_selfclr;
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && frame_done && !wr_ctl |=> load_strobe == 4'h0;
    endproperty
    a_selfclr: assert property (p_selfclr) else $error("strobe stuck");
    // strobes hold until the transaction ends or a new write
    property p_hold;
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && !frame_done && !wr_ctl |=> $stable(load_strobe);
    endproperty
    a_hold: assert property (p_hold) else $error("strobe moved");
    property p_map;
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && wr_ctl |=> load_strobe == $past(reg_wdata[15:12]);
    endproperty
    a_map: assert property (p_map) else $error("strobe map wrong");
    property p_mode;
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && wr_mode |=> output_kind_select == $past(reg_wdata[15:12]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not stored");
    // power write lands when no overcurrent clear can interfere
    property p_pwr;
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && wr_mode && !overcurrent_response_cfg
        |=> channel_power_on == $past(reg_wdata[11:8]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power not stored");
    // mode register reads back its fields over a zero low byte
    property p_rsvd;
        @(posedge ref_clk) disable iff (!rst_n_q)
        addr_hit(reg_addr, ADDR_MODE_PWR)
        |-> reg_rdata == {output_kind_select, channel_power_on, 8'h00};
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved nonzero");
    property p_transp;
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && latch_transparent_cfg[1] && ch_data_wr[1]
        |=> dac_code[23:12] == $past(ch_data[23:12]);
    endproperty
    a_transp: assert property (p_transp) else $error("no passthrough");
    property p_ovc;
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && overcurrent_response_cfg
        |=> (channel_power_on & $past(ovc_s2_q)) == 4'h0;
    endproperty
    a_ovc: assert property (p_ovc) else $error("power not cleared");
    property p_rd0;
        @(posedge ref_clk) disable iff (!rst_n_q)
        reg_addr == ADDR_LATCH_LOAD |-> reg_rdata == 16'h0000;
    endproperty
    a_rd0: assert property (p_rd0) else $error("strobe readable");
endmodule
`default_nettype wire

//--- rtl/dlm_pkg.sv
// dlm_pkg: constants for the latch-load and channel mode/power registers
package dlm_pkg;
    // ==================================================
    // register map
    localparam logic [7:0]  ADDR_LATCH_LOAD = 8'h04;
    localparam logic [7:0]  ADDR_MODE_PWR   = 8'h05;
    localparam int          NUM_CH          = 4;
    // ==================================================
    // field positions
    localparam int          STROBE_LSB      = 12;
    localparam int          KIND_LSB        = 12;
    localparam int          PWR_LSB         = 8;
    // ==================================================
    // reset values
    localparam logic [3:0]  KIND_RST        = 4'h0;
    localparam logic [3:0]  PWR_RST         = 4'h0;
    localparam logic [11:0] DATA_RST        = 12'h000;
endpackage

//--- bench/dlm_host.sv
// dlm_host: host-side model driving the register port
`timescale 1ns/10ps
`default_nettype none
module dlm_host (
    // clock
    input  wire logic         ref_clk,
    // register port
    output logic              reg_wr,
    output logic      [7:0]   reg_addr,
    output logic      [15:0]  reg_wdata,
    output logic              frame_done
);
    // ==================================================
    // host cycles; data is inverted once released so stale values show
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge ref_clk) {reg_wr, reg_wdata} = {1'b0, ~d};
    endtask
    task automatic fin;
        @(negedge ref_clk) frame_done = 1'b1;
        @(negedge ref_clk) frame_done = 1'b0;
    endtask
    // read select is combinational, so let it settle before sampling
    task automatic sel(input logic [7:0] a);
        @(negedge ref_clk) reg_addr = a;
        #1;
    endtask
    initial {reg_wr, reg_addr, reg_wdata, frame_done} = '0;
endmodule
`default_nettype wire

//--- bench/dac_latch_and_channel_mode_regs_bench.sv
// dac_latch_and_channel_mode_regs_bench: self-checking bench for dlm_regs
`timescale 1ns/10ps
`default_nettype none
module dac_latch_and_channel_mode_regs_bench;
    import dlm_pkg::*;
    // ==================================================
    // nets and model state
    logic        ref_clk = 0, nrst = 0, ovc = 0, reg_wr, frame_done;
    logic        ce = 1, pin = 0;
    logic [3:0]  ltc = 0, cdw = 0, ocd = 0, kind, pwr, stb;
    logic [7:0]  addr, m_kp;
    logic [15:0] wdat, rdat, v;
    logic [47:0] cd = 0, dac, e;
    int          n_errors = 0, checks_done = 0, m_dac[4];
    always #20 ref_clk = ~ref_clk;
    dlm_host host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_addr(addr),
        .reg_wdata(wdat), .frame_done(frame_done));
    dlm_regs uut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(ce),
        .reg_wr(reg_wr), .reg_addr(addr), .reg_wdata(wdat),
        .frame_done(frame_done), .reg_rdata(rdat),
        .latch_transparent_cfg(ltc), .overcurrent_response_cfg(ovc),
        .ch_data(cd), .ch_data_wr(cdw), .overcurrent_det(ocd),
        .external_latch_pin(pin), .dac_code(dac),
        .output_kind_select(kind), .channel_power_on(pwr),
        .load_strobe(stb));
    // ==================================================
    // compare helpers
    task automatic chk(input logic [79:0] x, g, input string n);
        checks_done++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic chk_dac;
        for (int i = 0; i < NUM_CH; i++) e[12*i +: 12] = m_dac[i][11:0];
        chk(e, dac, "dac_code");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==================================================
    // main sequence
    initial begin
        void'($urandom(46460));
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (3) @(negedge ref_clk);
        host.sel(ADDR_MODE_PWR);
        chk(0, {rdat, kind, pwr, stb, dac}, "reset state");
        $display("reset test done");
        // random mode and power words, reserved low byte must read zero
        repeat (4) begin
            v = 16'($urandom);
            host.wr(ADDR_MODE_PWR, v);
            chk({v[15:8], 8'h00}, rdat, "mode read");
            chk(v[15:8], {kind, pwr}, "kind power");
            m_kp = v[15:8];
        end
        $display("mode test done");
        // clock enable low: a write must not land
        ce = 1'b0;
        host.wr(ADDR_MODE_PWR, ~v);
        chk(m_kp, {kind, pwr}, "frozen regs");
        ce = 1'b1;
        $display("enable test done");
        // strobes against a random mix of latched and transparent channels
        repeat (6) begin
            cd = 48'({$urandom, $urandom});
            ltc = 4'($urandom);
            v = 16'($urandom);
            host.wr(ADDR_LATCH_LOAD, v);
            chk(v[15:12], stb, "strobe");
            chk(0, rdat, "strobe read");
            for (int i = 0; i < NUM_CH; i++)
                if (v[STROBE_LSB+i] && !ltc[i]) m_dac[i] = cd[12*i +: 12];
            @(negedge ref_clk);
            chk_dac;
            host.fin;
            chk(0, stb, "strobe clear");
        end
        $display("strobe test done");
        // a rising latch pin loads every latched channel, two sync flops
        cd = 48'({$urandom, $urandom});
        ltc = 4'($urandom);
        pin = 1'b1;
        for (int i = 0; i < NUM_CH; i++)
            if (!ltc[i]) m_dac[i] = cd[12*i +: 12];
        repeat (3) @(negedge ref_clk);
        chk_dac;
        pin = 1'b0;
        $display("pin test done");
        // transparent channels follow data writes and ignore strobes
        ltc = 4'hf;
        cd = 48'({$urandom, $urandom});
        cdw = 4'h5;
        @(negedge ref_clk);
        cdw = 4'h0;
        m_dac[0] = cd[11:0];
        m_dac[2] = cd[35:24];
        host.wr(ADDR_LATCH_LOAD, 16'hf000);
        @(negedge ref_clk);
        chk_dac;
        host.fin;
        $display("transparent test done");
        // unmapped write, then overcurrent in host mode and a rewrite
        ovc = 1'b1;
        host.wr(8'h06, 16'hffff);
        chk(0, rdat, "unmapped read");
        chk({m_kp, 4'h0}, {kind, pwr, stb}, "unmapped write");
        host.wr(ADDR_MODE_PWR, 16'h0f00);
        ocd = 4'h2;
        repeat (5) @(negedge ref_clk);
        ocd = 4'h0;
        // let the detector flush out of the synchroniser first
        repeat (3) @(negedge ref_clk);
        chk(16'h0d00, rdat, "overcurrent power");
        host.wr(ADDR_MODE_PWR, 16'h0f00);
        chk(4'hf, pwr, "power rewrite");
        $display("overcurrent test done");
        finish_test;
    end
endmodule
`default_nettype wire
